// *** src/rfs_pkg.sv ***
// Constants, types and helper functions shared by the rotate/fill/sleep execution block.
`default_nettype none
package rfs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_INSTR   = 8'h00;
  localparam logic [7:0] REG_CTRL    = 8'h04;
  localparam logic [7:0] REG_ACCUM   = 8'h08;
  localparam logic [7:0] REG_FLAGS   = 8'h0C;
  localparam logic [7:0] REG_POWER   = 8'h10;
  localparam logic [7:0] REG_INDEX   = 8'h14;
  localparam logic [7:0] REG_MEMADDR = 8'h18;
  localparam logic [7:0] REG_MEMDATA = 8'h1C;
  localparam logic [7:0] REG_WAKE    = 8'h20;
  localparam logic [7:0] REG_IRQSTAT = 8'h24;
  localparam logic [7:0] REG_IRQCLR  = 8'h28;
  localparam logic [7:0] REG_IRQEN   = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EXT      = 0;
  localparam int CTRL_WDT_EN   = 1;
  localparam int CTRL_PS_LSB   = 4;
  localparam int CTRL_BANK_LSB = 8;
  localparam int FLAG_C        = 0;
  localparam int FLAG_Z        = 2;
  localparam int FLAG_N        = 4;
  localparam int PWR_TO        = 0;
  localparam int PWR_PD        = 1;
  localparam int PWR_SLEEP     = 2;
  localparam int PWR_CNT_LSB   = 8;
  localparam int PWR_PS_LSB    = 16;
  localparam int WAKE_BIT      = 0;
  localparam int IRQ_W         = 4;
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_SLEEP     = 1;
  localparam int IRQ_WAKE      = 2;
  localparam int IRQ_WDT       = 3;

  // ----------------------------------------------------------------
  // Opcodes, addressing and values
  // ----------------------------------------------------------------
  localparam int          FILE_AW        = 12;
  localparam int          FILE_DEPTH     = 4096;
  localparam logic [5:0]  OPC_ROT        = 6'h10;
  localparam logic [6:0]  OPC_FILL       = 7'h34;
  localparam logic [15:0] OPC_SLEEP      = 16'h0003;
  localparam logic [7:0]  IDX_LIMIT      = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0]  FILL_VALUE     = 8'hFF;
  localparam logic [7:0]  WDT_CLEAR      = 8'h00;
  localparam logic [3:0]  PS_CLEAR       = 4'h0;
  localparam logic [9:0]  WDT_TICK_LAST  = 10'h3FF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4, ST_SLEEP} rfs_phase_t;

  typedef struct packed {
    logic                isRot;
    logic                isFill;
    logic                isSleep;
    logic                dest;
    logic [FILE_AW-1:0]  addr;
  } rfs_decode_t;

  // Effective file address for byte-oriented opcodes.
  function automatic logic [FILE_AW-1:0] fileAddr(input logic [15:0] op,
                                                 input logic        ext,
                                                 input logic [3:0]  bank,
                                                 input logic [11:0] index);
    logic [7:0] f;
    f = op[7:0];
    if (op[8])
      fileAddr = {bank, f};
    else if (ext && (f <= IDX_LIMIT))
      fileAddr = index + {4'h0, f};
    else if (f < ACCESS_SPLIT)
      fileAddr = {ACCESS_LO_BANK, f};
    else
      fileAddr = {ACCESS_HI_BANK, f};
  endfunction

  function automatic logic [7:0] rotr(input logic [7:0] v);
    rotr = {v[0], v[7:1]};
  endfunction

endpackage
`default_nettype wire

// *** src/rfs_watchdog.sv ***
// Watchdog counter with postscaler and tick divider.
`timescale 1ns/100ps
`default_nettype none
module rfs_watchdog (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       enable,
  input  wire logic       clear,
  input  wire logic [3:0] psLimit,
  output logic      [7:0] count,
  output logic      [3:0] postCount,
  output logic            expire
);
  import rfs_pkg::*;

  logic [9:0] tickDiv;
  logic [9:0] next_tickDiv;
  logic [7:0] next_count;
  logic [3:0] next_postCount;
  logic       next_expire;

  always_comb begin
    next_tickDiv   = tickDiv;
    next_count     = count;
    next_postCount = postCount;
    next_expire    = 1'b0;
    if (clear) begin
      // Clearing also restarts the divider so a full period follows.
      next_tickDiv   = '0;
      next_count     = WDT_CLEAR;
      next_postCount = PS_CLEAR;
    end else if (enable) begin
      next_tickDiv = tickDiv + 10'h001;
      if (tickDiv == WDT_TICK_LAST) begin
        next_count = count + 8'h01;
        if (count == 8'hFF) begin
          if (postCount == psLimit) begin
            next_postCount = PS_CLEAR;
            next_expire    = 1'b1;
          end else begin
            next_postCount = postCount + 4'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tickDiv   <= '0;
      count     <= WDT_CLEAR;
      postCount <= PS_CLEAR;
      expire    <= 1'b0;
    end else begin
      tickDiv   <= next_tickDiv;
      count     <= next_count;
      postCount <= next_postCount;
      expire    <= next_expire;
    end
  end
endmodule
`default_nettype wire

// *** src/rfs_exec.sv ***
// Execution core for rotate-right, fill-ones and sleep, with Avalon-MM registers.
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module rfs_exec (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  output logic             coreSleeping
);
  import rfs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rfs_phase_t         state,     next_state;
  rfs_decode_t        dec,       next_dec;
  logic [15:0]        instr,     next_instr;
  logic [7:0]         operand,   next_operand;
  logic [7:0]         result,    next_result;
  logic [15:0]        ctrl,      next_ctrl;
  logic [7:0]         accum,     next_accum;
  logic               carry,     next_carry;
  logic               zeroFlag,  next_zeroFlag;
  logic               negFlag,   next_negFlag;
  logic               toFlag,    next_toFlag;
  logic               pdFlag,    next_pdFlag;
  logic [11:0]        index,     next_index;
  logic [11:0]        memAddr,   next_memAddr;
  logic [IRQ_W-1:0]   irqStat,   next_irqStat;
  logic [IRQ_W-1:0]   irqEn,     next_irqEn;
  logic [31:0]        next_readdata;
  logic               next_waitrequest;
  logic               next_irq;
  logic               next_sleeping;
  logic [7:0]         fileMem [FILE_DEPTH];
  logic               memWe;
  logic [FILE_AW-1:0] memWa;
  logic [7:0]         memWd;
  logic               wdtClear;
  logic [7:0]         wdtCount;
  logic [3:0]         wdtPost;
  logic               wdtExpire;
  logic               busy;
  logic               wrDone;
  logic [IRQ_W-1:0]   irqSet;
  logic [IRQ_W-1:0]   irqClr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  assign busy   = (state == ST_Q1) || (state == ST_Q2) || (state == ST_Q3) || (state == ST_Q4);
  assign wrDone = avs_write && !avs_waitrequest;

  rfs_watchdog u_wdt (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .enable    (ctrl[CTRL_WDT_EN]),
    .clear     (wdtClear),
    .psLimit   (ctrl[CTRL_PS_LSB +: 4]),
    .count     (wdtCount),
    .postCount (wdtPost),
    .expire    (wdtExpire)
  );

  // ----------------------------------------------------------------
  // Instruction sequencer and datapath
  // ----------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_dec      = dec;
    next_instr    = instr;
    next_operand  = operand;
    next_result   = result;
    next_accum    = accum;
    next_carry    = carry;
    next_zeroFlag = zeroFlag;
    next_negFlag  = negFlag;
    next_toFlag   = toFlag;
    next_pdFlag   = pdFlag;
    memWe         = 1'b0;
    memWa         = memAddr;
    memWd         = avs_writedata[7:0];
    wdtClear      = 1'b0;
    irqSet        = '0;
    case (state)
      ST_IDLE: begin
        if (wrDone && avs_address == REG_INSTR && (&avs_byteenable[1:0])) begin
          next_instr = avs_writedata[15:0];
          next_state = ST_Q1;
        end
      end
      ST_Q1: begin
        next_dec.isRot   = (instr[15:10] == OPC_ROT);
        next_dec.isFill  = (instr[15:9] == OPC_FILL);
        next_dec.isSleep = (instr == OPC_SLEEP);
        next_dec.dest    = instr[9];
        next_dec.addr    = fileAddr(instr, ctrl[CTRL_EXT], ctrl[CTRL_BANK_LSB +: 4], index);
        next_state       = ST_Q2;
      end
      ST_Q2: begin
        // Sleep performs no operand fetch.
        if (dec.isRot || dec.isFill)
          next_operand = fileMem[dec.addr];
        next_state = ST_Q3;
      end
      ST_Q3: begin
        next_result = dec.isFill ? FILL_VALUE : rotr(operand);
        next_state  = ST_Q4;
      end
      ST_Q4: begin
        irqSet[IRQ_DONE] = 1'b1;
        next_state       = ST_IDLE;
        if (dec.isRot) begin
          next_negFlag  = result[7];
          next_zeroFlag = (result == 8'h00);
          if (dec.dest) begin
            memWe = 1'b1;
            memWa = dec.addr;
            memWd = result;
          end else begin
            next_accum = result;
          end
        end else if (dec.isFill) begin
          memWe = 1'b1;
          memWa = dec.addr;
          memWd = result;
        end else if (dec.isSleep) begin
          next_pdFlag       = 1'b0;
          next_toFlag       = 1'b1;
          wdtClear          = 1'b1;
          irqSet[IRQ_SLEEP] = 1'b1;
          next_state        = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wdtExpire) begin
          next_toFlag      = 1'b0;
          irqSet[IRQ_WAKE] = 1'b1;
          next_state       = ST_IDLE;
        end else if (wrDone && avs_address == REG_WAKE && avs_byteenable[0]
                     && avs_writedata[WAKE_BIT]) begin
          irqSet[IRQ_WAKE] = 1'b1;
          next_state       = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (wdtExpire && state != ST_SLEEP)
      irqSet[IRQ_WDT] = 1'b1;
    // Bus writes never coincide with phases Q1-Q4: the slave stalls while busy.
    if (wrDone) begin
      case (avs_address)
        REG_ACCUM: begin
          if (avs_byteenable[0])
            next_accum = avs_writedata[7:0];
        end
        REG_FLAGS: begin
          if (avs_byteenable[0]) begin
            next_carry    = avs_writedata[FLAG_C];
            next_zeroFlag = avs_writedata[FLAG_Z];
            next_negFlag  = avs_writedata[FLAG_N];
          end
        end
        REG_MEMDATA: begin
          memWe = avs_byteenable[0];
          memWa = memAddr;
          memWd = avs_writedata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state    <= ST_IDLE;
      dec      <= '0;
      instr    <= '0;
      operand  <= '0;
      result   <= '0;
      accum    <= '0;
      carry    <= 1'b0;
      zeroFlag <= 1'b0;
      negFlag  <= 1'b0;
      toFlag   <= 1'b1;
      pdFlag   <= 1'b1;
    end else begin
      state    <= next_state;
      dec      <= next_dec;
      instr    <= next_instr;
      operand  <= next_operand;
      result   <= next_result;
      accum    <= next_accum;
      carry    <= next_carry;
      zeroFlag <= next_zeroFlag;
      negFlag  <= next_negFlag;
      toFlag   <= next_toFlag;
      pdFlag   <= next_pdFlag;
    end
  end

  // File storage has no reset; software must initialise what it reads.
  always_ff @(posedge core_clk) begin
    if (memWe)
      fileMem[memWa] <= memWd;
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, configuration and interrupts
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl        = ctrl;
    next_index       = index;
    next_memAddr     = memAddr;
    next_irqEn       = irqEn;
    next_readdata    = avs_readdata;
    irqClr           = '0;
    // Every access takes one wait cycle; it stays stalled while an instruction runs.
    next_waitrequest = 1'b1;
    if ((avs_read || avs_write) && avs_waitrequest && !busy) begin
      next_waitrequest = 1'b0;
      next_readdata    = '0;
      case (avs_address)
        REG_INSTR:   next_readdata[15:0] = instr;
        REG_CTRL:    next_readdata[15:0] = ctrl;
        REG_ACCUM:   next_readdata[7:0]  = accum;
        REG_FLAGS: begin
          next_readdata[FLAG_C] = carry;
          next_readdata[FLAG_Z] = zeroFlag;
          next_readdata[FLAG_N] = negFlag;
        end
        REG_POWER: begin
          next_readdata[PWR_TO]               = toFlag;
          next_readdata[PWR_PD]               = pdFlag;
          next_readdata[PWR_SLEEP]            = coreSleeping;
          next_readdata[PWR_CNT_LSB +: 8]     = wdtCount;
          next_readdata[PWR_PS_LSB +: 4]      = wdtPost;
        end
        REG_INDEX:   next_readdata[11:0] = index;
        REG_MEMADDR: next_readdata[11:0] = memAddr;
        REG_MEMDATA: next_readdata[7:0]  = fileMem[memAddr];
        REG_IRQSTAT: next_readdata[IRQ_W-1:0] = irqStat;
        REG_IRQEN:   next_readdata[IRQ_W-1:0] = irqEn;
        default:     next_readdata = '0;
      endcase
    end
    if (wrDone) begin
      case (avs_address)
        REG_CTRL:    next_ctrl    = 16'(merge({16'h0000, ctrl}, avs_writedata, avs_byteenable));
        REG_INDEX:   next_index   = 12'(merge({20'h00000, index}, avs_writedata, avs_byteenable));
        REG_MEMADDR: next_memAddr = 12'(merge({20'h00000, memAddr}, avs_writedata, avs_byteenable));
        REG_IRQCLR: begin
          if (avs_byteenable[0])
            irqClr = avs_writedata[IRQ_W-1:0];
        end
        REG_IRQEN: begin
          if (avs_byteenable[0])
            next_irqEn = avs_writedata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // A new event in the cycle of its clear survives the clear.
    next_irqStat  = (irqStat & ~irqClr) | irqSet;
    next_irq      = |(next_irqStat & next_irqEn);
    next_sleeping = (next_state == ST_SLEEP);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl            <= '0;
      index           <= '0;
      memAddr         <= '0;
      irqStat         <= '0;
      irqEn           <= '0;
      avs_readdata    <= '0;
      avs_waitrequest <= 1'b1;
      irq             <= 1'b0;
      coreSleeping    <= 1'b0;
    end else begin
      ctrl            <= next_ctrl;
      index           <= next_index;
      memAddr         <= next_memAddr;
      irqStat         <= next_irqStat;
      irqEn           <= next_irqEn;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      irq             <= next_irq;
      coreSleeping    <= next_sleeping;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  carry_kept_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q3 && dec.isRot) |=> ##1 (carry == $past(carry, 2)
      && negFlag == result[7] && zeroFlag == (result == 8'h00)))
    else $error("rotate changed carry or set wrong N/Z");
  rot_accum_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q3 && dec.isRot && !dec.dest) |=> ##1 (accum == rotr($past(operand, 2))))
    else $error("rotate to accumulator gave wrong value");
  rot_file_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q4 && dec.isRot && dec.dest) |-> (memWe && memWa == dec.addr
      && memWd == rotr(operand) && $stable(accum)))
    else $error("rotate to file register gave wrong write");
  bank_select_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q1 && instr[8]) |=> (dec.addr == {$past(ctrl[CTRL_BANK_LSB +: 4]),
      $past(instr[7:0])}))
    else $error("banked address does not follow bank pointer");
  indexed_mode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q1 && !instr[8] && ctrl[CTRL_EXT] && instr[7:0] <= IDX_LIMIT)
      |=> (dec.addr == $past(index) + {4'h0, $past(instr[7:0])}))
    else $error("indexed offset address wrong");
  fill_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q4 && dec.isFill) |-> (memWe && memWd == FILL_VALUE && memWa == dec.addr)
      ##1 ($stable(zeroFlag) && $stable(negFlag) && $stable(carry)))
    else $error("fill did not write FFh or touched flags");
  sleep_flags_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q4 && dec.isSleep) |=> (!pdFlag && toFlag))
    else $error("sleep flags wrong");
  wdt_cleared_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q4 && dec.isSleep) |=> (wdtCount == WDT_CLEAR && wdtPost == PS_CLEAR))
    else $error("watchdog not cleared by sleep");
  wdt_wake_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_SLEEP && wdtExpire) |=> (!toFlag && state == ST_IDLE && !coreSleeping))
    else $error("watchdog wake did not clear time-out flag");
  phase_order_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q1) |=> (state == ST_Q2) ##1 (state == ST_Q3) ##1 (state == ST_Q4))
    else $error("instruction phases out of order");
  sleep_halt_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == ST_Q2 && dec.isSleep) |=> $stable(operand) ##2 (state == ST_SLEEP && coreSleeping))
    else $error("sleep read a register or did not halt");
endmodule
`default_nettype wire

// *** testbench/rotate_fill_sleep_exec_test.sv ***
// Self-checking bench for the rotate, fill and sleep execution block.
`timescale 1ns/100ps
`default_nettype none
module rotate_fill_sleep_exec_test;
  import rfs_pkg::*;
  logic        core_clk        = 1'b0;
  logic        rstn            = 1'b0;
  logic [7:0]  avs_address     = 8'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [3:0]  avs_byteenable  = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        coreSleeping;
  int          nErrors         = 0;
  int          samplesChecked  = 0;
  logic [31:0] seed            = 32'h908F;
  logic [7:0]  mem [int];
  int          accum           = 0;
  int          flags           = 0;
  int          fF [5]          = '{32'h70, 32'h33, 32'h5F, 32'h60, 32'h22};
  int          fA [5]          = '{0, 1, 0, 0, 1};
  int          fX [5]          = '{0, 0, 1, 1, 1};
  int          fAd [5]         = '{32'hF70, 32'h533, 32'h01F, 32'hF60, 32'h522};

  rfs_exec dut_u (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq),
    .coreSleeping    (coreSleeping)
  );

  always #2.5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Each access starts one edge after the last so no strobe is driven twice in a step.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) check(32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic setMem(input int ad, input logic [7:0] v);
    wr(REG_MEMADDR, ad);
    wr(REG_MEMDATA, {24'h0, v});
    mem[ad] = v;
  endtask

  task automatic memCheck(input int ad);
    logic [31:0] q;
    wr(REG_MEMADDR, ad);
    rd(REG_MEMDATA, q);
    check({24'h0, q[7:0]}, {24'h0, mem[ad]});
  endtask

  task automatic wrapUp();
    $display("checks=%0d errors=%0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : mainSeq
    logic [31:0] q;
    logic [31:0] t;
    logic [7:0]  v;
    logic [7:0]  r;
    int          ad;
    int          f;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    rd(REG_POWER, q);
    check({30'h0, q[1:0]}, 32'h3);
    rd(8'hFC, q);
    check(q, 32'h0);
    $display("test reset done");
    wr(REG_CTRL, 32'h500);
    for (int i = 0; i < 6; i++) begin
      t = xs();
      v = (i == 0) ? 8'h00 : (i == 2) ? 8'hD7 : (i == 1) ? 8'h01 : t[7:0];
      f = 16 + i * 20;
      ad = i[1] ? 32'h500 + f : (f < 32'h60 ? f : 32'hF00 + f);
      setMem(ad, v);
      t = xs();
      flags = t & 32'h15;
      wr(REG_FLAGS, flags);
      wr(REG_INSTR, {16'h0, OPC_ROT, i[0], i[1], f[7:0]});
      r = {v[0], v[7:1]};
      flags = (flags & 32'h01) | (r[7] << 4) | ((r == 8'h00) << 2);
      if (i[0]) mem[ad] = r;
      else accum = r;
      rd(REG_ACCUM, q);
      check(q, accum);
      rd(REG_FLAGS, q);
      check(q, flags);
      memCheck(ad);
    end
    $display("test rotate done");
    wr(REG_INDEX, 32'hFC0);
    setMem(32'h05F, 8'h5A);
    setMem(32'h020, 8'hA5);
    for (int i = 0; i < 5; i++) begin
      wr(REG_CTRL, 32'h500 | fX[i]);
      t = xs();
      setMem(fAd[i], t[7:0]);
      wr(REG_INSTR, {16'h0, OPC_FILL, fA[i][0], fF[i][7:0]});
      mem[fAd[i]] = FILL_VALUE;
      memCheck(fAd[i]);
      rd(REG_FLAGS, q);
      check(q, flags);
      rd(REG_ACCUM, q);
      check(q, accum);
    end
    memCheck(32'h05F);
    memCheck(32'h020);
    $display("test fill done");
    wr(REG_CTRL, 32'h532);
    wr(REG_IRQEN, 32'h0);
    setMem(32'h533, 8'h5A);
    repeat (2100) @(posedge core_clk);
    wr(REG_INSTR, {16'h0, OPC_SLEEP});
    repeat (3) @(posedge core_clk);
    #1 check({31'h0, coreSleeping}, 32'h0);
    @(posedge core_clk);
    #1 check({31'h0, coreSleeping}, 32'h1);
    rd(REG_POWER, q);
    check(q & 32'hFFF07, 32'h5);
    rd(REG_IRQSTAT, q);
    check(q & 32'h2, 32'h2);
    check({31'h0, irq}, 32'h0);
    wr(REG_IRQEN, 32'h2);
    repeat (2) @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h1);
    wr(REG_INSTR, {16'h0, OPC_FILL, 1'b1, 8'h33});
    wr(REG_IRQCLR, 32'h2);
    repeat (2) @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h0);
    wr(REG_WAKE, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 check({31'h0, coreSleeping}, 32'h0);
    rd(REG_POWER, q);
    check({29'h0, q[2:0]}, 32'h1);
    memCheck(32'h533);
    wr(REG_INSTR, 32'h0000FFFF);
    rd(REG_ACCUM, q);
    check(q, accum);
    rd(REG_IRQSTAT, q);
    check(q, 32'h5);
    $display("test sleep done");
    wrapUp();
  end

  // A hang in any wait above ends here as a failure.
  initial begin : watchdogSeq
    repeat (40000) @(posedge core_clk);
    nErrors++;
    wrapUp();
  end
endmodule
`default_nettype wire
